// ==== src/burner_fault_regs.svh ====
// constants of the burner fault manager: timing, codes, history depth
// assumes a 100 MHz system clock
`ifndef BURNER_FAULT_REGS_SVH
`define BURNER_FAULT_REGS_SVH
`define CYC_PER_MS 32'd100000
`define RESET_HOLD_MS 32'd2000
`define RELAY_DELAY_MS 32'd3000
`define RESTART_DELAY_MS 32'd3000
`define REPEAT_INT_MS 32'd10000
`define O2_HIST_MS 32'd5000
`define O2_PERSIST_MS 32'd30000
`define FLASH_HALF_MS 32'd250
`define HIST_DEPTH 4'd10
`define O2_SHUT_VALUE 8'h01
`define FLAME_CODE_MIN 4'h2
`define FLAME_CODE_MAX 4'hA
`define CODE_FLAME_RUN 9'h004
`define CODE_COMM_OVF 9'h066
`define CODE_DIN_DIFF 9'h06C
`define CODE_CRC_FAIL 9'h06E
`define CODE_RAM_FAIL 9'h06F
`define CODE_MODE_DIFF 9'h078
`define CODE_CORR_BASE 9'h079
`define CODE_O2_SHUT 9'h168
`endif

// ==== src/burner_fault_pkg.sv ====
// types shared by the burner fault manager and its hold timer
// assumes burner_fault_regs.svh on the include path
`include "burner_fault_regs.svh"
package burner_fault_pkg;
   typedef enum logic [1:0] {view_status, view_load, view_history,
      view_o2} view_type;
   typedef enum logic [1:0] {cls_none, cls_single, cls_repeat} restart_type;
   typedef enum logic [1:0] {st_ok, st_fault, st_restart} fault_state_type;
   typedef struct packed {
      logic origin_mon;
      logic [8:0] code;
   } code_type;
   typedef struct packed {
      code_type code;
      logic [31:0] stamp;
   } hist_entry_type;
   typedef struct packed {
      logic [7:0] ext_load;
      logic [7:0] int_load;
   } load_type;
   typedef struct packed {
      logic [3:0] flame_code;
      logic comm_ovf;
      logic crc_fail;
      logic ram_fail;
      logic din_diff;
      logic mode_diff;
      logic [4:0] corr_range;
      logic origin_mon;
   } fault_src_type;
   typedef struct packed {
      code_type code;
      logic [31:0] stamp;
      logic show_text;
      load_type load;
      logic o2_hist_open;
   } display_type;
   typedef struct packed {
      logic valid;
      code_type code;
      logic [31:0] stamp;
   } nv_write_type;
   typedef struct packed {
      logic [31:0] cnt;
      logic done;
   } timer_state_type;
   typedef struct packed {
      fault_state_type st;
      code_type code;
      logic [31:0] stamp;
      load_type load;
      restart_type cls;
      logic tried;
      logic [31:0] tmr;
      logic relay;
      logic restart;
      logic show_text;
      logic ext_meta;
      logic ext_sync;
      logic ext_done_d;
      hist_entry_type [`HIST_DEPTH-1:0] hist;
      logic [3:0] wr;
      logic [3:0] cnt;
      logic [3:0] step;
      logic o2_latched;
      logic o2_air;
      logic o2_pend;
      logic o2_seen;
      code_type o2_code;
      logic [31:0] o2_stamp;
      logic o2_open;
      logic [31:0] o2_tmr;
      logic [31:0] flash_cnt;
      logic flash;
      display_type disp;
      nv_write_type nv;
   } mgr_state_type;
endpackage

// ==== src/hold_timer.sv ====
// hold timer: done while the level has been high at least LIMIT cycles
// assumes level_in is already on the system clock
`timescale 1ns/1ps
module hold_timer #(
   parameter int unsigned LIMIT = 32'd2
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // level and result
   input wire logic level_in,
   output logic done_out
);
   import burner_fault_pkg::*;
   timer_state_type r_reg, r_next;

   always_comb begin
      r_next = r_reg;
      if (!level_in) begin
         r_next.cnt = 32'd0;
         r_next.done = 1'b0;
      end else if (r_reg.cnt < LIMIT - 32'd1) begin
         r_next.cnt = r_reg.cnt + 32'd1;
      end else begin
         r_next.done = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign done_out = r_reg.done;

   AST_HOLD_DROP: assert property ( // see RULE4 see RULE14
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      !level_in |=> !done_out)
      else $error("hold timer done without level");
   AST_HOLD_MIN: assert property ( // see RULE4
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      $rose(done_out) |-> r_reg.cnt == LIMIT - 32'd1)
      else $error("hold timer done too early");
endmodule

// ==== src/burner_fault_manager.sv ====
// burner fault manager: safe state, relay delay, clearing, history,
// oxygen regulator errors, restart control and fault code encoding
// assumes panel keys, fault sources and counters come from logic on
// sys_clk_in as one-cycle key pulses; only the reset terminal is a pin
// Contract
// RULE1: any fault drives all actuators to their safe direction
// RULE2: fuel valves drop at once, fault relay energises after a delay
// RULE3: panel reset in status view clears fault unless cause present
// RULE4: reset terminal clears fault only if held two seconds
// RULE5: keep last ten faults with code and running time stamp
// RULE6: in history view each channel 1 up steps to next older fault
// RULE7: status view shows code; acceptance shows text and time stamp
// RULE8: capture external and internal load at fault, show in load view
// RULE9: oxygen perturbation warns, disables regulator, sets base value; the code raises o2_air_base_out only on air shortage
// RULE10: air shortage outputs its base value, shuts down if set to 1
// RULE11: oxygen forced shutdown reported with its own main code
// RULE12: oxygen errors clear at every start-up and on manual clear
// RULE13: oxygen history view closes after five seconds
// RULE14: oxygen fault recorded only when lasting over thirty seconds
// RULE15: oxygen record written when fault clears or mode leaves regulation
// RULE16: every code carries a main or monitoring origin tag
// RULE17: single class restarts once, repeat class retries at interval
// RULE18: fault indicator flashes while a repeat start-up is pending
// RULE19: flame supervision failures use codes two to ten
// RULE20: self-test failures use codes 102, 110 and 111
// RULE21: processor input or mode disagreement gives codes 108 and 120
// RULE22: channel correction out of range gives codes 121 to 125
// RULE23: a full history overwrites its oldest entry
`timescale 1ns/1ps
`include "burner_fault_regs.svh"
module burner_fault_manager #(
   parameter int unsigned RESET_HOLD_CYC = `RESET_HOLD_MS * `CYC_PER_MS,
   parameter int unsigned RELAY_CYC = `RELAY_DELAY_MS * `CYC_PER_MS,
   parameter int unsigned RESTART_CYC = `RESTART_DELAY_MS * `CYC_PER_MS,
   parameter int unsigned REPEAT_CYC = `REPEAT_INT_MS * `CYC_PER_MS,
   parameter bit REPEAT_EN = 1'b1,
   parameter int unsigned O2_HIST_CYC = `O2_HIST_MS * `CYC_PER_MS,
   parameter int unsigned O2_PERSIST_CYC = `O2_PERSIST_MS * `CYC_PER_MS,
   parameter int unsigned FLASH_CYC = `FLASH_HALF_MS * `CYC_PER_MS
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // fault sources and burner context
   input wire burner_fault_pkg::fault_src_type fault_src_in,
   input wire logic fault_present_in,
   input wire logic fuel_demand_in,
   input wire logic [31:0] runtime_in,
   input wire burner_fault_pkg::load_type load_in,
   input wire logic burner_start_in,
   // reset terminal pin
   input wire logic ext_reset_pin_in,
   // operator panel
   input wire burner_fault_pkg::view_type view_in,
   input wire logic key_reset_in,
   input wire logic key_accept_in,
   input wire logic key_ch1_up_in,
   input wire logic key_o2_hist_in,
   // oxygen regulator
   input wire logic o2_perturb_in,
   input wire logic o2_air_short_in,
   input wire logic [8:0] o2_code_in,
   input wire logic [7:0] o2_shut_cfg_in,
   input wire logic o2_clear_in,
   input wire logic reg_mode_in,
   // actuators and relays
   output logic act_safe_out,
   output logic fuel_valve_en_out,
   output logic fault_relay_out,
   output logic fault_led_out,
   output logic restart_req_out,
   // oxygen regulator control
   output logic o2_reg_en_out,
   output logic o2_air_base_out,
   output logic o2_warn_out,
   // display and nonvolatile record
   output burner_fault_pkg::display_type display_out,
   output burner_fault_pkg::nv_write_type nv_write_out
);
   import burner_fault_pkg::*;
   mgr_state_type r_reg, r_next;
   logic det;
   code_type det_code;
   restart_type det_cls;
   logic ext_done;
   logic o2_err;
   logic o2_qual;
   logic pend_restart;
   logic [31:0] wait_cyc;
   logic [3:0] hist_idx;

   assign o2_err = o2_perturb_in | o2_air_short_in;

   hold_timer #(
      .LIMIT(RESET_HOLD_CYC)
   ) u_ext_hold (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .level_in(r_reg.ext_sync),
      .done_out(ext_done)
   );

   hold_timer #(
      .LIMIT(O2_PERSIST_CYC)
   ) u_o2_persist (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .level_in(o2_err),
      .done_out(o2_qual)
   );

   // fault encoder, highest priority last
   always_comb begin
      det = 1'b0;
      det_code = '0;
      det_cls = cls_none;
      det_code.origin_mon = fault_src_in.origin_mon; // see RULE16
      if (fault_src_in.flame_code >= `FLAME_CODE_MIN &&
          fault_src_in.flame_code <= `FLAME_CODE_MAX) begin
         det = 1'b1;
         det_code.code = {5'h00, fault_src_in.flame_code}; // see RULE19
         if (det_code.code == `CODE_FLAME_RUN) begin
            det_cls = cls_repeat;
         end
      end
      for (int i = 4; i >= 0; i--) begin
         if (fault_src_in.corr_range[i]) begin
            det = 1'b1;
            det_code.code = `CODE_CORR_BASE + 9'(i); // see RULE22
            det_code.origin_mon = 1'b1;
            det_cls = cls_none;
         end
      end
      if (fault_src_in.mode_diff) begin
         det = 1'b1;
         det_code.code = `CODE_MODE_DIFF; // see RULE21
         det_cls = cls_single;
      end
      if (fault_src_in.din_diff) begin
         det = 1'b1;
         det_code.code = `CODE_DIN_DIFF; // see RULE21
         det_code.origin_mon = 1'b0;
         det_cls = cls_none;
      end
      if (fault_src_in.comm_ovf | fault_src_in.crc_fail |
          fault_src_in.ram_fail) begin
         det = 1'b1;
         det_cls = cls_none;
         det_code.code = fault_src_in.ram_fail ? `CODE_RAM_FAIL : // see RULE20
            fault_src_in.crc_fail ? `CODE_CRC_FAIL : `CODE_COMM_OVF;
      end
      if (o2_air_short_in && o2_shut_cfg_in == `O2_SHUT_VALUE) begin
         det = 1'b1; // see RULE10
         det_code.code = `CODE_O2_SHUT; // see RULE11
         det_code.origin_mon = 1'b0;
         det_cls = cls_none;
      end
   end

   always_comb begin
      r_next = r_reg;
      r_next.restart = 1'b0;
      r_next.nv.valid = 1'b0;
      r_next.ext_meta = ext_reset_pin_in;
      r_next.ext_sync = r_reg.ext_meta;
      r_next.ext_done_d = ext_done;
      pend_restart = (det_cls == cls_single && !r_reg.tried) ||
         (det_cls == cls_repeat && REPEAT_EN); // see RULE17
      wait_cyc = (r_reg.cls == cls_single) ? RESTART_CYC : REPEAT_CYC;
      hist_idx = (r_reg.wr >= r_reg.step) ? 4'(r_reg.wr - r_reg.step) :
         4'(r_reg.wr + `HIST_DEPTH - r_reg.step);
      unique case (r_reg.st)
         st_ok: begin
            r_next.relay = 1'b0;
            if (det) begin
               r_next.st = pend_restart ? st_restart : st_fault;
               r_next.code = det_code;
               r_next.stamp = runtime_in;
               r_next.load = load_in; // see RULE8
               r_next.cls = det_cls;
               r_next.tmr = 32'd0;
               r_next.show_text = 1'b0;
               if (det_cls == cls_single) begin
                  r_next.tried = 1'b1;
               end
               r_next.hist[r_reg.wr] = {det_code, runtime_in}; // see RULE5
               r_next.wr = (r_reg.wr == `HIST_DEPTH - 4'd1) ? 4'd0 :
                  4'(r_reg.wr + 4'd1); // see RULE23
               if (r_reg.cnt < `HIST_DEPTH) begin
                  r_next.cnt = 4'(r_reg.cnt + 4'd1);
               end
            end
         end
         st_fault, st_restart: begin
            if (r_reg.tmr != 32'hFFFFFFFF) begin
               r_next.tmr = r_reg.tmr + 32'd1;
            end
            r_next.relay = (r_reg.tmr >= RELAY_CYC - 32'd1); // see RULE2
            if (r_reg.st == st_restart && r_reg.tmr >= wait_cyc - 32'd1) begin
               r_next.st = st_ok; // see RULE17
               r_next.restart = 1'b1;
               r_next.relay = 1'b0;
            end
            if ((view_in == view_status && key_reset_in &&
                 !fault_present_in) || // see RULE3
                (ext_done && !r_reg.ext_done_d)) begin // see RULE4
               r_next.st = st_ok;
               r_next.relay = 1'b0;
               r_next.tried = 1'b0;
            end
         end
         default: begin
            r_next.st = st_ok;
         end
      endcase
      if (view_in != view_status && view_in != view_history) begin
         r_next.show_text = 1'b0;
      end else if (key_accept_in) begin
         r_next.show_text = 1'b1; // see RULE7
      end
      if (view_in != view_history) begin
         r_next.step = 4'd0;
      end else if (key_ch1_up_in && r_reg.step < r_reg.cnt) begin
         r_next.step = 4'(r_reg.step + 4'd1); // see RULE6
      end
      // oxygen errors: a new error wins over a clear
      if (burner_start_in | o2_clear_in) begin
         r_next.o2_latched = 1'b0; // see RULE12
         r_next.o2_air = 1'b0;
      end
      if (o2_err) begin
         r_next.o2_latched = 1'b1; // see RULE9
      end
      if (o2_air_short_in) begin
         r_next.o2_air = 1'b1; // see RULE10
      end
      if (!o2_err) begin
         r_next.o2_seen = 1'b0;
      end else if (o2_qual && !r_reg.o2_seen) begin
         r_next.o2_seen = 1'b1; // see RULE14
         r_next.o2_pend = 1'b1;
         r_next.o2_code = {1'b0, o2_code_in};
         r_next.o2_stamp = runtime_in;
      end
      if (r_reg.o2_pend && (!o2_err || !reg_mode_in)) begin
         r_next.o2_pend = 1'b0; // see RULE15
         r_next.nv = {1'b1, r_reg.o2_code, r_reg.o2_stamp};
      end
      if (key_o2_hist_in) begin
         r_next.o2_open = 1'b1;
         r_next.o2_tmr = 32'd0;
      end else if (r_reg.o2_open) begin
         r_next.o2_tmr = r_reg.o2_tmr + 32'd1;
         if (r_reg.o2_tmr >= O2_HIST_CYC - 32'd1) begin
            r_next.o2_open = 1'b0; // see RULE13
         end
      end
      if (r_reg.st != st_restart || r_reg.flash_cnt >= FLASH_CYC - 32'd1)
      begin
         r_next.flash_cnt = 32'd0;
         r_next.flash = (r_reg.st == st_restart) ? !r_reg.flash : 1'b1;
      end else begin
         r_next.flash_cnt = r_reg.flash_cnt + 32'd1;
      end
      r_next.disp = '0;
      r_next.disp.o2_hist_open = r_next.o2_open;
      r_next.disp.show_text = r_next.show_text;
      unique case (view_in)
         view_status: begin
            if (r_reg.st != st_ok) begin
               r_next.disp.code = r_reg.code; // see RULE7
               r_next.disp.stamp = r_next.show_text ? r_reg.stamp : 32'd0;
            end
         end
         view_load: begin
            r_next.disp.load = r_reg.load; // see RULE8
         end
         view_history: begin
            if (r_reg.step != 4'd0) begin
               r_next.disp.code = r_reg.hist[hist_idx].code; // see RULE6
               r_next.disp.stamp = r_reg.hist[hist_idx].stamp;
            end
         end
         view_o2: begin
            r_next.disp.code = r_reg.o2_code;
            r_next.disp.stamp = r_reg.o2_stamp;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // safe drive and fuel shut-off act in the detecting cycle
   assign act_safe_out = (r_reg.st != st_ok) || det; // see RULE1
   assign fuel_valve_en_out = fuel_demand_in && r_reg.st == st_ok &&
      !det; // see RULE2
   assign fault_relay_out = r_reg.relay;
   assign fault_led_out = (r_reg.st == st_restart) ? r_reg.flash :
      (r_reg.st == st_fault); // see RULE18
   assign restart_req_out = r_reg.restart;
   assign o2_reg_en_out = !r_reg.o2_latched;
   assign o2_air_base_out = r_reg.o2_air;
   assign o2_warn_out = r_reg.o2_latched;
   assign display_out = r_reg.disp;
   assign nv_write_out = r_reg.nv;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   AST_SAFE_DRIVE: assert property ( // see RULE1
      r_reg.st != st_ok |-> act_safe_out && !fuel_valve_en_out)
      else $error("fault without safe drive");
   AST_RELAY_DELAY: assert property ( // see RULE2
      fault_relay_out |-> r_reg.st != st_ok && r_reg.tmr >= RELAY_CYC)
      else $error("fault relay energised early");
   AST_PANEL_CLEAR: assert property ( // see RULE3
      r_reg.st == st_fault && view_in == view_status && key_reset_in &&
      !fault_present_in |=> r_reg.st == st_ok && !fault_relay_out)
      else $error("panel reset did not clear");
   AST_PANEL_KEEP: assert property ( // see RULE3
      r_reg.st == st_fault && key_reset_in && fault_present_in &&
      !(ext_done && !r_reg.ext_done_d) |=> r_reg.st == st_fault)
      else $error("fault cleared with cause present");
   AST_HIST_PUSH: assert property ( // see RULE5
      r_reg.st == st_ok && det |=> r_reg.cnt != 4'd0 &&
      r_reg.cnt <= `HIST_DEPTH && r_reg.code == $past(det_code))
      else $error("fault not stored");
   AST_O2_OFF: assert property ( // see RULE9
      o2_err |=> !o2_reg_en_out && o2_warn_out)
      else $error("oxygen regulator left enabled");
   AST_O2_SHUT: assert property ( // see RULE11
      r_reg.st == st_ok && o2_air_short_in &&
      o2_shut_cfg_in == `O2_SHUT_VALUE |=> r_reg.code.code == `CODE_O2_SHUT)
      else $error("oxygen shutdown code wrong");
   AST_O2_VIEW: assert property ( // see RULE13
      r_reg.o2_open |-> r_reg.o2_tmr < O2_HIST_CYC)
      else $error("oxygen history view stayed open");
   AST_LED_STEADY: assert property ( // see RULE18
      r_reg.st == st_fault |-> fault_led_out)
      else $error("fault indicator not steady");
   AST_RESTART_ONE: assert property ( // see RULE17
      restart_req_out |-> $past(r_reg.st) == st_restart && r_reg.st == st_ok)
      else $error("restart without pending state");

   COV_RESTART: cover property (restart_req_out);
   COV_EXT_CLEAR: cover property (r_reg.st == st_fault ##1
      r_reg.st == st_ok && r_reg.ext_done_d);
   COV_HIST_STEP: cover property (r_reg.step == 4'd2);
   COV_NV_WRITE: cover property (nv_write_out.valid);
endmodule

// ==== bench/burner_plant_model.sv ====
// plant model: running time meter, load signals and fuel demand
// assumes the same clock and synchronous reset as the fault manager
`timescale 1ns/1ps
module burner_plant_model (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // plant state seen by the fault manager
   output logic [31:0] runtime_out,
   output burner_fault_pkg::load_type load_out,
   output logic fuel_demand_out
);
   import burner_fault_pkg::*;
   // the meter runs whenever powered, so every cycle has its own stamp
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         runtime_out <= 32'h00000000;
      end else begin
         runtime_out <= runtime_out + 32'h00000001;
      end
   end
   // loads move all the time so a late capture shows up
   assign load_out = '{ext_load: runtime_out[9:2],
      int_load: ~runtime_out[7:0]};
   assign fuel_demand_out = ~sys_rst_in;
endmodule

// ==== bench/burner_fault_manager_tb.sv ====
// bench for the burner fault manager with a plant model beside it
// assumes short timing parameters; inputs change 1 ns after the edge
`timescale 1ns/1ps
module burner_fault_manager_tb;
   import burner_fault_pkg::*;
   localparam int unsigned HOLD = 20;
   localparam int unsigned RELAY = 10;
   localparam int unsigned RSTRT = 15;
   localparam int unsigned REP = 25;
   localparam int unsigned O2H = 12;
   localparam int unsigned O2P = 30;
   logic sys_clk_in, sys_rst_in, present, start, pin, k_rst, k_acc, k_up;
   logic k_o2, perturb, air, o2_clr, demand, safe, fuel_en, relay, led;
   logic rreq, reg_en, air_base, warn, mode, nv_valid;
   fault_src_type src;
   view_type view;
   logic [8:0] o2_code;
   logic [7:0] shut_cfg;
   logic [31:0] runtime, t_stamp;
   load_type load, t_load;
   display_type disp;
   nv_write_type nv;
   int err_count, n_compared;
   logic [41:0] hq[$];

   assign nv_valid = nv.valid;

   burner_plant_model plant (.sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in), .runtime_out(runtime), .load_out(load),
      .fuel_demand_out(demand));

   burner_fault_manager #(.RESET_HOLD_CYC(HOLD), .RELAY_CYC(RELAY),
      .RESTART_CYC(RSTRT), .REPEAT_CYC(REP), .REPEAT_EN(1'b1),
      .O2_HIST_CYC(O2H), .O2_PERSIST_CYC(O2P), .FLASH_CYC(3)) uut (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .fault_src_in(src), .fault_present_in(present),
      .fuel_demand_in(demand), .runtime_in(runtime), .load_in(load),
      .burner_start_in(start), .ext_reset_pin_in(pin), .view_in(view),
      .key_reset_in(k_rst), .key_accept_in(k_acc), .key_ch1_up_in(k_up),
      .key_o2_hist_in(k_o2), .o2_perturb_in(perturb),
      .o2_air_short_in(air), .o2_code_in(o2_code),
      .o2_shut_cfg_in(shut_cfg), .o2_clear_in(o2_clr),
      .reg_mode_in(mode), .act_safe_out(safe), .fuel_valve_en_out(fuel_en),
      .fault_relay_out(relay), .fault_led_out(led), .restart_req_out(rreq),
      .o2_reg_en_out(reg_en), .o2_air_base_out(air_base),
      .o2_warn_out(warn), .display_out(disp), .nv_write_out(nv));

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   task automatic chk(input string nm, input logic [41:0] exp,
         input logic [41:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask
   task automatic wait_hi(ref logic s, input int lim, output int n);
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         cyc(1);
         n++;
      end
   endtask
   // call right after raising a cause; judges the detecting cycle
   task automatic detect(input logic [9:0] exp);
      #1;
      chk("act_safe", 1, safe);
      chk("fuel_en", 0, fuel_en);
      t_stamp = runtime;
      t_load = load;
      cyc(1);
      src = '0;
      cyc(1);
      chk("code", exp, disp.code);
      hq.push_front({exp, t_stamp});
      if (hq.size() > 10) void'(hq.pop_back());
   endtask
   task automatic clear_panel();
      pulse(k_rst);
      cyc(1);
      chk("safe_clr", 0, safe);
      chk("relay_clr", 0, relay);
      chk("fuel_on", 1, fuel_en);
   endtask
   task automatic one(input fault_src_type s, input logic [9:0] c);
      src = s;
      detect(c);
      clear_panel();
   endtask

   task automatic t_detect();
      src.ram_fail = 1'b1;
      detect(10'h06F);
      cyc(RELAY - 3);
      chk("relay_early", 0, relay);
      cyc(5);
      chk("relay", 1, relay);
      chk("led", 1, led);
      pulse(k_acc);
      cyc(1);
      chk("text", 1, disp.show_text);
      chk("stamp", t_stamp, disp.stamp);
      view = view_load;
      cyc(2);
      chk("load", t_load, disp.load);
      view = view_status;
      present = 1'b1;
      pulse(k_rst);
      cyc(1);
      chk("held", 1, safe);
      present = 1'b0;
      clear_panel();
      src.crc_fail = 1'b1;
      src.origin_mon = 1'b1;
      detect(10'h26E);
      pin = 1'b1;
      cyc(HOLD - 4);
      pin = 1'b0;
      cyc(6);
      chk("pin_short", 1, safe);
      pin = 1'b1;
      cyc(HOLD + 5);
      pin = 1'b0;
      cyc(1);
      chk("pin_long", 0, safe);
      cyc(4);
      $display("test detect and clear done");
   endtask

   task automatic t_codes();
      one('{comm_ovf: 1'b1, default: '0}, 10'h066);
      one('{din_diff: 1'b1, default: '0}, 10'h06C);
      one('{ram_fail: 1'b1, flame_code: 4'h2, default: '0}, 10'h06F);
      for (int i = 0; i < 5; i++) begin
         one('{corr_range: 5'h01 << i, default: '0},
            10'h279 + 10'(i));
      end
      one('{flame_code: 4'h2, default: '0}, 10'h002);
      src.flame_code = 4'hA;
      src.origin_mon = 1'b1;
      detect(10'h20A);
      clear_panel();
      $display("test codes done");
   endtask

   task automatic t_restart();
      int n;
      logic l;
      src.mode_diff = 1'b1;
      detect(10'h078);
      wait_hi(rreq, 40, n);
      chk("single", 1, n + 3 >= RSTRT && n <= RSTRT + 3);
      cyc(1);
      chk("restarted", 0, safe);
      src.mode_diff = 1'b1;
      detect(10'h078);
      wait_hi(rreq, RSTRT + 10, n);
      chk("once", RSTRT + 10, n);
      clear_panel();
      src.flame_code = 4'h4;
      detect(10'h004);
      n = 0;
      repeat (12) begin
         l = led;
         cyc(1);
         if (led !== l) n++;
      end
      chk("flash", 1, n >= 3);
      wait_hi(rreq, REP + 10, n);
      chk("repeat", 1, rreq);
      cyc(2);
      view = view_history;
      for (int i = 0; i < 11; i++) begin
         pulse(k_up);
         cyc(1);
         chk("hist", hq[i < 10 ? i : 9], {disp.code, disp.stamp});
      end
      view = view_status;
      $display("test restart and history done");
   endtask

   task automatic t_o2();
      int n;
      o2_code = 9'h0AB;
      perturb = 1'b1;
      cyc(2);
      chk("reg_off", 0, reg_en);
      chk("warn", 1, warn);
      chk("no_shut", 0, safe);
      wait_hi(nv_valid, O2P + 5, n);
      chk("nv_early", O2P + 5, n);
      perturb = 1'b0;
      wait_hi(nv_valid, 5, n);
      chk("nv_valid", 1, nv_valid);
      chk("nv_code", 9'h0AB, nv.code.code);
      perturb = 1'b1;
      cyc(O2P + 3);
      mode = 1'b0;
      wait_hi(nv_valid, 5, n);
      chk("nv_mode", 1, nv_valid);
      perturb = 1'b0;
      mode = 1'b1;
      pulse(start);
      cyc(1);
      chk("start_clr", 1, reg_en);
      perturb = 1'b1;
      cyc(10);
      perturb = 1'b0;
      wait_hi(nv_valid, 8, n);
      chk("nv_short", 8, n);
      air = 1'b1;
      cyc(2);
      chk("air_base", 1, air_base);
      chk("air_noshut", 0, safe);
      air = 1'b0;
      pulse(o2_clr);
      cyc(1);
      chk("man_clr", 1, reg_en);
      shut_cfg = 8'h01;
      air = 1'b1;
      wait_hi(safe, 5, n);
      cyc(2);
      chk("o2_code", 10'h168, disp.code);
      air = 1'b0;
      pulse(o2_clr);
      clear_panel();
      view = view_o2;
      pulse(k_o2);
      cyc(1);
      chk("o2_open", 1, disp.o2_hist_open);
      cyc(O2H - 4);
      chk("o2_still", 1, disp.o2_hist_open);
      cyc(6);
      chk("o2_closed", 0, disp.o2_hist_open);
      $display("test oxygen done");
   endtask

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   initial begin
      #50000;
      err_count++;
      complete_run();
   end
   initial begin
      {present, start, pin, k_rst, k_acc, k_up, k_o2} = '0;
      {perturb, air, o2_clr} = '0;
      src = '0;
      view = view_status;
      o2_code = 9'h000;
      shut_cfg = 8'h00;
      mode = 1'b1;
      sys_rst_in = 1'b1;
      err_count = 0;
      n_compared = 0;
      cyc(12);
      sys_rst_in = 1'b0;
      cyc(2);
      t_detect();
      t_codes();
      t_restart();
      t_o2();
      complete_run();
   end
endmodule
